//--- hw/lmr_map.svh
`ifndef LMR_MAP_SVH
`define LMR_MAP_SVH

// Command field codes on cmd_addr_bus bits 3:0 at the rising edge
`define LMR_OP_W 4
`define LMR_OP_RD 4'h8
`define LMR_OP_WR 4'h0

// Register addresses
`define LMR_A_ID 8'h00
`define LMR_A_CFG1 8'h01
`define LMR_A_CFG2 8'h02
`define LMR_A_CFG3 8'h03
`define LMR_A_TEMP 8'h04
`define LMR_A_ZQ 8'h0A
`define LMR_A_BANK 8'h10
`define LMR_A_SEG 8'h11
`define LMR_A_CALA 8'h20
`define LMR_A_CALB 8'h28
`define LMR_A_RESET 8'h3F

// Reset values
`define LMR_RST_CFG 8'h00
`define LMR_RST_MASK 8'h00
`define LMR_RST_TEMP 3'h3
// Arbitrary identification value
`define LMR_ID_VAL 8'h5A

// Field layout of the temperature status register
`define LMR_TEMP_W 3
`define LMR_TEMP_LSB 0

// Calibration patterns, bit n is beat n
`define LMR_PAT_A 4'h5
`define LMR_PAT_B 4'hC

// Timing
`define LMR_RL 3
`define LMR_BEATS 4
`define LMR_CLK_KHZ 50000
`define LMR_TSI_MS 32
`define LMR_TSI_CYC (`LMR_TSI_MS * `LMR_CLK_KHZ)

`endif

//--- hw/lmr_pkg.sv
package lmr_pkg;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CAPT = 2'b01,
        ST_LAT = 2'b10,
        ST_BURST = 2'b11
    } lmr_state_t;

    // Pins from outside the clock domain, synchronised as one group
    typedef struct packed {
        logic ck;
        logic cs_n;
        logic [9:0] ca;
        logic [2:0] temp;
        logic lp;
    } lmr_pins_t;

endpackage

//--- hw/lmr_sync.sv
`timescale 1ns/1ps
`default_nettype none
module lmr_sync #(
    parameter int W = 1
) (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic ce_in,
    input wire logic [W-1:0] d_in,
    output wire logic [W-1:0] q_out
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } lmr_sync_st_t;

    lmr_sync_st_t st;
    lmr_sync_st_t next_st;

    always_comb begin
        next_st.s1 = d_in;
        next_st.s2 = st.s1;
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            st <= '0;
        end else if (ce_in) begin
            st <= next_st;
        end
    end

    assign q_out = st.s2;
endmodule // lmr_sync
`default_nettype wire

//--- hw/lmr_temp.sv
`timescale 1ns/1ps
`default_nettype none
`include "lmr_map.svh"
module lmr_temp #(
    parameter int TSI_CYC = `LMR_TSI_CYC
) (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic ce_in,
    input wire logic [`LMR_TEMP_W-1:0] code_in,
    input wire logic wake_in,
    output wire logic [`LMR_TEMP_W-1:0] code_out
);
    localparam int CW = $clog2(TSI_CYC + 1);
    localparam logic [CW-1:0] LAST = CW'(TSI_CYC - 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic [`LMR_TEMP_W-1:0] code;
    } lmr_temp_st_t;

    lmr_temp_st_t st;
    lmr_temp_st_t next_st;

    // Wake from low power resamples at once so the status is never stale
    always_comb begin
        next_st = st;
        if (wake_in || st.cnt == LAST) begin // [RULE_12]
            next_st.cnt = '0;
            next_st.code = code_in;
        end else begin
            next_st.cnt = st.cnt + CW'(1);
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            st <= '{cnt: '0, code: `LMR_RST_TEMP};
        end else if (ce_in) begin
            st <= next_st;
        end
    end

    assign code_out = st.code;

    default clocking @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);

    temp_interval_a: assert property (st.cnt <= LAST) else $error("temp interval exceeded"); // [RULE_12]
    temp_wake_a: assert property (wake_in && ce_in |=> st.code == $past(code_in)) else $error("wake resample"); // [RULE_12]
endmodule // lmr_temp
`default_nettype wire

//--- hw/lmr_top.sv
// Operation
// [RULE_01] Read command: select low, bits 0-2 low, 3 high
// [RULE_02] Address from falling bits 1:0 over rising 9:4
// [RULE_03] Register byte on lanes 0-7, first beat, after latency
// [RULE_04] All strobes toggle for whole read burst
// [RULE_05] Read burst is four beats, never cut short
// [RULE_06] Controller sends only no-ops for two clocks
// [RULE_07] Reserved or write-only reads give undefined values
// [RULE_08] Lanes 8 and up undefined during ordinary reads
// [RULE_09] Controller spaces read before later writes
// [RULE_10] Controller spaces data read before register read
// [RULE_11] Controller spaces data write before register read
// [RULE_12] Temperature status refreshed within 32 ms interval
// [RULE_13] Controller polls temperature fast enough for margin
// [RULE_14] Temperature status in bits 2:0 of register
// [RULE_15] Pattern reads drive lane 0, mirrored per byte
// [RULE_16] Other lanes copy lane 0 pattern
// [RULE_17] Pattern A is 1010, pattern B 0011
// [RULE_18] Controller reads patterns only while idle
// [RULE_19] Write command: select and bits 0-3 low
// [RULE_20] Writes to read-only registers are ignored
// [RULE_21] Controller writes only with all banks idle
// [RULE_22] Masked banks and segments skip self refresh
// [RULE_23] Controller sends no-ops during write period
// [RULE_24] Write to reset address restores register defaults
`timescale 1ns/1ps
`default_nettype none
`include "lmr_map.svh"
module lmr_top #(
    parameter int DQ_W = 16,
    parameter int RL = `LMR_RL,
    parameter int TSI_CYC = `LMR_TSI_CYC,
    parameter int NB = 8,
    parameter int NSEG = 8,
    parameter logic [7:0] ID_VAL = `LMR_ID_VAL
) (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic ce_in,
    input wire logic link_ck_in,
    input wire logic cs_n_in,
    input wire logic [9:0] ca_in,
    input wire logic [2:0] temp_code_in,
    input wire logic low_power_in,
    output wire logic [DQ_W-1:0] dq_out,
    output wire logic dq_oe_out,
    output wire logic [DQ_W/8-1:0] dqs_t_out,
    output wire logic [DQ_W/8-1:0] dqs_c_out,
    output wire logic dqs_oe_out,
    output wire logic [23:0] mode_cfg_out,
    output wire logic [NB*NSEG-1:0] refresh_masked_out,
    output wire logic soft_reset_out,
    output wire logic busy_out
);
    import lmr_pkg::*;

    localparam int NS = DQ_W / 8;
    localparam logic [3:0] RL_CNT = 4'(RL);

    typedef struct packed {
        lmr_state_t fsm;
        logic ck_d;
        logic lp_d;
        logic is_rd;
        logic [5:0] ca_r;
        logic [3:0] cnt;
        logic [1:0] beat;
        logic [7:0] rd_byte;
        logic cal;
        logic [3:0] pat;
        logic [7:0] cfg1;
        logic [7:0] cfg2;
        logic [7:0] cfg3;
        logic [7:0] bank;
        logic [7:0] seg;
        logic [DQ_W-1:0] dq;
        logic dq_oe;
        logic [NS-1:0] dqs_t;
        logic [NS-1:0] dqs_c;
        logic dqs_oe;
        logic [NB*NSEG-1:0] ref_mask;
        logic soft_rst;
        logic busy;
    } lmr_top_st_t;

    lmr_top_st_t st;
    lmr_top_st_t next_st;
    lmr_pins_t raw_pins;
    lmr_pins_t pins;
    logic [`LMR_TEMP_W-1:0] temp_code;
    logic rise;
    logic fall;
    logic wake;
    logic [7:0] addr;
    logic [7:0] wr_data;

    // Writable registers; the calibration one takes writes but reads back undefined
    function automatic logic wr_ok(input logic [7:0] a);
        return a == `LMR_A_CFG1 || a == `LMR_A_CFG2 || a == `LMR_A_CFG3 ||
               a == `LMR_A_ZQ || a == `LMR_A_BANK || a == `LMR_A_SEG;
    endfunction

    assign raw_pins = '{ck: link_ck_in, cs_n: cs_n_in, ca: ca_in, temp: temp_code_in, lp: low_power_in};

    lmr_sync #(
        .W($bits(lmr_pins_t))
    ) u_sync (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .ce_in(ce_in),
        .d_in(raw_pins),
        .q_out(pins)
    );

    lmr_temp #(
        .TSI_CYC(TSI_CYC)
    ) u_temp (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .ce_in(ce_in),
        .code_in(pins.temp),
        .wake_in(wake),
        .code_out(temp_code)
    );

    // Link clock passes the two-stage synchroniser, so edges show two system cycles after the pin changes
    assign rise = pins.ck && !st.ck_d;
    assign fall = !pins.ck && st.ck_d;
    assign wake = st.lp_d && !pins.lp;
    assign addr = {pins.ca[1:0], st.ca_r}; // [RULE_02]
    assign wr_data = pins.ca[9:2]; // [RULE_19]

    always_comb begin
        next_st = st;
        next_st.ck_d = pins.ck;
        next_st.lp_d = pins.lp;
        next_st.soft_rst = 1'b0;
        unique case (st.fsm)
            ST_IDLE: begin
                // Commands other than the two register ones are not ours
                if (rise && !pins.cs_n && pins.ca[2:0] == 3'h0) begin // [RULE_01] [RULE_19]
                    next_st.is_rd = pins.ca[3];
                    next_st.ca_r = pins.ca[9:4];
                    next_st.fsm = ST_CAPT;
                end
            end
            ST_CAPT: begin
                if (fall) begin
                    if (st.is_rd) begin
                        next_st.cal = 1'b0;
                        next_st.pat = `LMR_PAT_A;
                        next_st.cnt = RL_CNT;
                        next_st.fsm = ST_LAT;
                        unique case (addr)
                            `LMR_A_ID: next_st.rd_byte = ID_VAL;
                            `LMR_A_CFG1: next_st.rd_byte = st.cfg1;
                            `LMR_A_CFG2: next_st.rd_byte = st.cfg2;
                            `LMR_A_CFG3: next_st.rd_byte = st.cfg3;
                            `LMR_A_TEMP: next_st.rd_byte = 8'(temp_code) << `LMR_TEMP_LSB; // [RULE_14]
                            `LMR_A_BANK: next_st.rd_byte = st.bank;
                            `LMR_A_SEG: next_st.rd_byte = st.seg;
                            `LMR_A_CALA: begin
                                next_st.cal = 1'b1; // [RULE_17]
                                next_st.rd_byte = 8'h00;
                            end
                            `LMR_A_CALB: begin
                                next_st.cal = 1'b1;
                                next_st.pat = `LMR_PAT_B; // [RULE_17]
                                next_st.rd_byte = 8'h00;
                            end
                            default: next_st.rd_byte = 8'h00; // [RULE_07]
                        endcase
                    end else begin
                        next_st.fsm = ST_IDLE;
                        if (addr == `LMR_A_RESET) begin // [RULE_24]
                            next_st.cfg1 = `LMR_RST_CFG;
                            next_st.cfg2 = `LMR_RST_CFG;
                            next_st.cfg3 = `LMR_RST_CFG;
                            next_st.bank = `LMR_RST_MASK;
                            next_st.seg = `LMR_RST_MASK;
                            next_st.soft_rst = 1'b1;
                        end else if (wr_ok(addr)) begin // [RULE_20]
                            if (addr == `LMR_A_CFG1) next_st.cfg1 = wr_data;
                            if (addr == `LMR_A_CFG2) next_st.cfg2 = wr_data;
                            if (addr == `LMR_A_CFG3) next_st.cfg3 = wr_data;
                            if (addr == `LMR_A_BANK) next_st.bank = wr_data;
                            if (addr == `LMR_A_SEG) next_st.seg = wr_data;
                        end
                    end
                end
            end
            ST_LAT: begin
                // The command's own rising edge is not counted here
                if (rise) begin
                    if (st.cnt <= 4'h1) begin // [RULE_03]
                        next_st.fsm = ST_BURST;
                        next_st.beat = 2'h0;
                    end else begin
                        next_st.cnt = st.cnt - 4'h1;
                    end
                end
            end
            ST_BURST: begin
                // No command is decoded here, so nothing can cut the burst
                if (rise || fall) begin // [RULE_05]
                    if (st.beat == 2'(`LMR_BEATS - 1)) begin
                        next_st.fsm = ST_IDLE;
                    end else begin
                        next_st.beat = st.beat + 2'h1;
                    end
                end
            end
        endcase

        next_st.dq_oe = next_st.fsm == ST_BURST;
        next_st.dqs_oe = next_st.fsm == ST_BURST;
        // Registered so the pin never carries decode glitches
        next_st.busy = next_st.fsm != ST_IDLE;
        next_st.dqs_t = next_st.dqs_oe ? {NS{~next_st.beat[0]}} : '0; // [RULE_04]
        next_st.dqs_c = ~next_st.dqs_t;
        next_st.dq = '0; // [RULE_08]
        if (next_st.dq_oe) begin
            if (next_st.cal) begin
                // Every lane copies lane 0 rather than driving zero
                next_st.dq = {DQ_W{next_st.pat[next_st.beat]}}; // [RULE_15] [RULE_16]
            end else if (next_st.beat == 2'h0) begin
                next_st.dq[7:0] = next_st.rd_byte; // [RULE_03]
            end
        end

        for (int b = 0; b < NB; b++) begin
            for (int s = 0; s < NSEG; s++) begin
                next_st.ref_mask[b*NSEG+s] = next_st.bank[b] | next_st.seg[s]; // [RULE_22]
            end
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            st <= '0;
        end else if (ce_in) begin
            st <= next_st;
        end
    end

    assign dq_out = st.dq;
    assign dq_oe_out = st.dq_oe;
    assign dqs_t_out = st.dqs_t;
    assign dqs_c_out = st.dqs_c;
    assign dqs_oe_out = st.dqs_oe;
    assign mode_cfg_out = {st.cfg3, st.cfg2, st.cfg1};
    assign refresh_masked_out = st.ref_mask;
    assign soft_reset_out = st.soft_rst;
    assign busy_out = st.busy;

    logic [39:0] kept_regs;
    assign kept_regs = {st.cfg1, st.cfg2, st.cfg3, st.bank, st.seg};

    default clocking @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);

    sequence cmd_edge_s;
        ce_in && rise && !pins.cs_n && st.fsm == ST_IDLE;
    endsequence

    sequence wr_take_s;
        ce_in && st.fsm == ST_CAPT && fall && !st.is_rd;
    endsequence

    rd_cmd_seen_a: assert property (cmd_edge_s and pins.ca[3:0] == `LMR_OP_RD |=> st.fsm == ST_CAPT && st.is_rd)
        else $error("read command missed"); // [RULE_01]
    wr_cmd_seen_a: assert property (cmd_edge_s and pins.ca[3:0] == `LMR_OP_WR |=> st.fsm == ST_CAPT && !st.is_rd)
        else $error("write command missed"); // [RULE_19]
    wr_data_take_a: assert property (wr_take_s and addr == `LMR_A_BANK |=> st.bank == $past(wr_data))
        else $error("write data not stored"); // [RULE_02]
    ro_write_a: assert property (wr_take_s and !wr_ok(addr) && addr != `LMR_A_RESET |=> $stable(kept_regs))
        else $error("read-only write changed state"); // [RULE_20]
    soft_reset_a: assert property (wr_take_s and addr == `LMR_A_RESET |=> soft_reset_out && kept_regs == '0)
        else $error("reset write did not restore"); // [RULE_24]
    first_beat_a: assert property (ce_in && st.fsm == ST_LAT && rise && st.cnt == 4'h1 |=>
        st.dq_oe && st.beat == 2'h0 && (st.cal || st.dq[7:0] == st.rd_byte))
        else $error("first beat wrong"); // [RULE_03]
    burst_len_a: assert property (ce_in && st.fsm == ST_BURST && (rise || fall) && st.beat != 2'h3 |=>
        st.fsm == ST_BURST && st.beat == $past(st.beat) + 2'h1)
        else $error("burst cut short"); // [RULE_05]
    strobe_a: assert property (st.dq_oe |-> st.dqs_oe && st.dqs_t == {NS{~st.beat[0]}} && st.dqs_c == ~st.dqs_t)
        else $error("strobe not toggling"); // [RULE_04]
    upper_lanes_a: assert property (st.dq_oe && !st.cal |-> st.dq[DQ_W-1:8] == '0 && (st.beat == 2'h0 || st.dq == '0))
        else $error("undefined lanes not quiet"); // [RULE_08]
    cal_lanes_a: assert property (st.dq_oe && st.cal |-> st.dq == {DQ_W{st.pat[st.beat]}})
        else $error("calibration pattern wrong"); // [RULE_15]
    bank_mask_a: assert property (ce_in && st.fsm == ST_IDLE && st.bank[0] |=> refresh_masked_out[NSEG-1:0] == '1)
        else $error("masked bank still refreshed"); // [RULE_22]
endmodule // lmr_top
`default_nettype wire

//--- verif/lmr_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module lmr_ctrl_model (
    input wire logic clk_in,
    output logic link_ck_out,
    output logic cs_n_out,
    output logic [9:0] ca_out
);
    // Link clock rests low between frames
    initial begin
        link_ck_out = 1'b0;
        cs_n_out = 1'b1;
        ca_out = 10'h000;
    end

    // One command period, then no-ops with the clock running for the burst
    task automatic send(input logic [3:0] op, input logic [7:0] addr, input logic [7:0] wdata,
                        input int periods);
        @(posedge clk_in);
        #2;
        cs_n_out = 1'b0;
        ca_out = {addr[5:0], op};
        #40;
        link_ck_out = 1'b1;
        #40;
        ca_out = {wdata, addr[7:6]};
        #40;
        link_ck_out = 1'b0;
        #40;
        cs_n_out = 1'b1;
        // Released bus shows no stale value
        ca_out = ~ca_out;
        for (int i = 1; i < periods; i++) begin
            #40;
            link_ck_out = 1'b1;
            #80;
            link_ck_out = 1'b0;
            #40;
            ca_out = ~ca_out;
        end
    endtask
endmodule // lmr_ctrl_model
`default_nettype wire

//--- verif/sdram_mode_register_access_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "lmr_map.svh"
module sdram_mode_register_access_test;
    import lmr_pkg::*;
    logic clk_in;
    logic arst_n_in;
    logic link_ck;
    logic cs_n;
    logic [9:0] ca;
    logic [2:0] temp_code;
    logic low_power;
    logic [15:0] dq;
    logic dq_oe;
    logic [1:0] dqs_t;
    logic [1:0] dqs_c;
    logic dqs_oe;
    logic [23:0] mode_cfg;
    logic [63:0] refresh_masked;
    logic soft_reset;
    logic busy_out;
    int mismatches;
    int cmp_count;
    int cycles;
    int pulses;
    logic [15:0] beat_q[$];
    logic [4:0] stb_q[$];
    logic prev_oe;
    logic prev_t;

    lmr_top #(.TSI_CYC(50)) dut (
        .clk_in(clk_in), .arst_n_in(arst_n_in), .ce_in(1'b1), .link_ck_in(link_ck), .cs_n_in(cs_n),
        .ca_in(ca), .temp_code_in(temp_code), .low_power_in(low_power), .dq_out(dq), .dq_oe_out(dq_oe),
        .dqs_t_out(dqs_t), .dqs_c_out(dqs_c), .dqs_oe_out(dqs_oe), .mode_cfg_out(mode_cfg),
        .refresh_masked_out(refresh_masked), .soft_reset_out(soft_reset), .busy_out(busy_out)
    );
    lmr_ctrl_model ctrl (.clk_in(clk_in), .link_ck_out(link_ck), .cs_n_out(cs_n), .ca_out(ca));

    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end

    // Each strobe toggle opens a new beat; sampled mid-cycle where outputs are settled
    always @(negedge clk_in) begin
        if (dqs_oe === 1'b1 && (prev_oe !== 1'b1 || dqs_t[0] !== prev_t)) begin
            beat_q.push_back(dq);
            stb_q.push_back({dq_oe, dqs_t, dqs_c});
        end
        if (soft_reset === 1'b1) pulses++;
        prev_oe <= dqs_oe;
        prev_t <= dqs_t[0];
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            finish_test();
        end
    end

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        while (busy_out !== 1'b0 && n < 100) begin
            @(posedge clk_in);
            n++;
        end
        check("busy", busy_out, 1'b0);
        repeat (4) @(posedge clk_in);
    endtask

    task automatic do_write(input logic [7:0] a, input logic [7:0] d);
        ctrl.send(`LMR_OP_WR, a, d, 2);
        wait_idle();
    endtask

    task automatic do_read(input logic [7:0] a);
        beat_q.delete();
        stb_q.delete();
        ctrl.send(`LMR_OP_RD, a, 8'h00, 8);
        wait_idle();
        check("beat count", beat_q.size(), 4);
        for (int i = 0; i < 4; i++) begin
            check("strobes", stb_q[i], (i % 2 == 0) ? 5'h1C : 5'h13);
        end
    endtask

    // Byte on lanes 7:0 in beat 0 only, rest driven low
    task automatic check_reg(input logic [7:0] a, input logic [7:0] v);
        do_read(a);
        check("beat 0", beat_q[0], {8'h00, v});
        for (int i = 1; i < 4; i++) begin
            check("later beat", beat_q[i], 16'h0000);
        end
    endtask

    task automatic test_plain_reads();
        logic [7:0] res[3];
        res = '{8'h0A, 8'h3F, 8'h05};
        check_reg(8'h00, 8'h5A);
        foreach (res[i]) check_reg(res[i], 8'h00);
        $display("test plain_reads done");
    endtask

    task automatic test_calibration();
        logic [3:0] pat;
        for (int p = 0; p < 2; p++) begin
            pat = (p == 0) ? 4'h5 : 4'hC;
            do_read((p == 0) ? 8'h20 : 8'h28);
            for (int i = 0; i < 4; i++) begin
                check("pattern beat", beat_q[i], {16{pat[i]}});
            end
        end
        $display("test calibration done");
    endtask

    task automatic test_writes();
        do_write(8'h01, 8'hA5);
        do_write(8'h02, 8'h3C);
        do_write(8'h03, 8'h81);
        check("cfg", mode_cfg, 24'h81_3CA5);
        // Upper address bits differ only in the second half
        do_write(8'h41, 8'hFF);
        check("cfg", mode_cfg, 24'h81_3CA5);
        check_reg(8'h02, 8'h3C);
        do_write(8'h00, 8'h11);
        do_write(8'h04, 8'h07);
        check_reg(8'h00, 8'h5A);
        check_reg(8'h04, 8'h03);
        $display("test writes done");
    endtask

    task automatic test_masks();
        logic [63:0] exp;
        do_write(8'h10, 8'h82);
        do_write(8'h11, 8'h84);
        for (int b = 0; b < 8; b++) begin
            for (int s = 0; s < 8; s++) begin
                exp[b * 8 + s] = (b == 1 || b == 7 || s == 2 || s == 7);
            end
        end
        check("refresh mask", refresh_masked, exp);
        check_reg(8'h11, 8'h84);
        $display("test masks done");
    endtask

    task automatic test_temperature();
        @(posedge clk_in);
        #2;
        temp_code = 3'h5;
        repeat (70) @(posedge clk_in);
        check_reg(8'h04, 8'h05);
        #2;
        low_power = 1'b1;
        temp_code = 3'h6;
        repeat (5) @(posedge clk_in);
        #2;
        low_power = 1'b0;
        repeat (10) @(posedge clk_in);
        check_reg(8'h04, 8'h06);
        $display("test temperature done");
    endtask

    task automatic test_soft_reset();
        pulses = 0;
        do_write(8'h3F, 8'h00);
        check("reset pulses", pulses, 1);
        check("cfg", mode_cfg, 24'h00_0000);
        check("refresh mask", refresh_masked, 64'h0000_0000_0000_0000);
        check_reg(8'h10, 8'h00);
        $display("test soft_reset done");
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        arst_n_in = 1'b0;
        temp_code = 3'h3;
        low_power = 1'b0;
        mismatches = 0;
        cmp_count = 0;
        cycles = 0;
        pulses = 0;
        repeat (3) @(posedge clk_in);
        #2;
        arst_n_in = 1'b1;
        repeat (4) @(posedge clk_in);
        test_plain_reads();
        test_calibration();
        test_writes();
        test_masks();
        test_temperature();
        test_soft_reset();
        finish_test();
    end
endmodule // sdram_mode_register_access_test
`default_nettype wire
